// [sim/pia_sec_model.sv]
// Purpose: latching secondary flags feeding the aggregator
// Assumes: one flag per primary, set wins over clear
// Notes: flags stay set until a write-one clear
`timescale 1ns/1ps
`default_nettype none

module pia_sec_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // events, clears and secondary masks
    input wire logic [15:0] set_flags,
    input wire logic [15:0] clr_flags,
    input wire logic [15:0] sec_mask,
    // per primary or of unmasked flags
    output logic [15:0] secondary_any
);
    logic [15:0] flags;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 16'h0000;
        end else begin
            flags <= (flags & ~clr_flags) | set_flags;
        end
    end

    assign secondary_any = flags & ~sec_mask;
endmodule

`default_nettype wire

// [sim/test_primary_interrupt_aggregator.sv]
// Purpose: self-checking bench for the aggregator
// Assumes: zero wait state APB slave, status one edge behind flags
// Notes: model of flags, masks and config kept in the bench
`timescale 1ns/1ps
`default_nettype none

module test_primary_interrupt_aggregator;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_n_out, irq_n_oe, err;
    logic [15:0] paddr, set_flags, clr_flags, sec_mask, secondary_any, m_flags, m_mask, bit_i;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] m_cfg;
    int n_mismatch, checks_done;

    pia_top #(.NUM_BITS(16)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .secondary_any(secondary_any),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    pia_sec_model u_sec (.core_clk(core_clk), .rst_n(rst_n), .set_flags(set_flags),
        .clr_flags(clr_flags), .sec_mask(sec_mask), .secondary_any(secondary_any));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_mask(input logic [15:0] v);
        apb(1'b1, pia_pkg::ADDR_MASK, {16'hffff, v});
        m_mask = v & pia_pkg::VALID_BITS;
    endtask

    task automatic settle;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic pulse(input logic [15:0] s, input logic [15:0] c);
        @(posedge core_clk);
        set_flags <= s;
        clr_flags <= c;
        m_flags = (m_flags & ~c) | s;
        @(posedge core_clk);
        set_flags <= 16'h0000;
        clr_flags <= 16'h0000;
        settle();
    endtask

    task automatic chk_status;
        apb(1'b0, pia_pkg::ADDR_STATUS, 32'h0);
        chk(rd, {16'h0000, m_flags & ~sec_mask & pia_pkg::VALID_BITS});
    endtask

    task automatic chk_pin;
        logic req;
        req = |(m_flags & ~sec_mask & pia_pkg::VALID_BITS & ~m_mask) & ~m_cfg[0];
        if (m_cfg[1]) begin
            chk({30'h0, irq_n_out, irq_n_oe}, {30'h0, 1'b0, req});
        end else begin
            chk({30'h0, irq_n_out, irq_n_oe}, {30'h0, ~req, 1'b1});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {set_flags, clr_flags, sec_mask, m_flags} = '0;
        pstrb = 4'hf;
        m_mask = pia_pkg::MASK_RESET;
        m_cfg = 2'h0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        void'($urandom(33));
        apb(1'b0, pia_pkg::ADDR_MASK, 32'h0);
        chk(rd, 32'h0000_f9b3);
        chk_pin();
        apb(1'b1, pia_pkg::ADDR_STATUS, 32'hffff_ffff);
        chk_status();
        wr_mask(16'hffff);
        apb(1'b0, pia_pkg::ADDR_MASK, 32'h0);
        chk(rd, {16'h0000, m_mask});
        pstrb <= 4'h1;
        apb(1'b1, pia_pkg::ADDR_MASK, 32'h0000_ff00);
        m_mask[7:0] = 8'h00;
        pstrb <= 4'hf;
        apb(1'b0, pia_pkg::ADDR_MASK, 32'h0);
        chk(rd, {16'h0000, m_mask});
        for (int i = 0; i < 16; i++) begin
            bit_i = 16'h0001 << i;
            wr_mask(~bit_i);
            pulse(bit_i, 16'h0000);
            chk_status();
            chk_pin();
            wr_mask(16'hffff);
            settle();
            chk_pin();
            chk_status();
            sec_mask <= bit_i;
            settle();
            chk_status();
            sec_mask <= 16'h0000;
            pulse(16'h0000, bit_i);
            chk_status();
        end
        wr_mask(16'h0000);
        pulse(16'h0001, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, pia_pkg::ADDR_CONFIG, c);
            m_cfg = c[1:0];
            settle();
            chk_pin();
            apb(1'b0, pia_pkg::ADDR_CONFIG, 32'h0);
            chk(rd, {30'h0, m_cfg});
        end
        apb(1'b0, 16'h4000, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b0, 16'h4011, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, pia_pkg::ADDR_CONFIG, 32'h0);
        m_cfg = 2'h0;
        repeat (40) begin
            wr_mask(16'($urandom));
            sec_mask <= 16'($urandom);
            pulse(16'($urandom), 16'($urandom));
            chk_status();
            chk_pin();
        end
        give_verdict();
    end
endmodule

`default_nettype wire

// [verilog/pia_apb_decode.sv]
// Purpose: APB phase and address decode for the aggregator
// Assumes: word aligned registers, zero wait states
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none

module pia_apb_decode (
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic [15:0] paddr,
    // decoded
    output logic setup,
    output logic access,
    output logic hit_status,
    output logic hit_mask,
    output logic hit_config,
    output logic unmapped
);
    always_comb begin
        setup = psel & ~penable;
        access = psel & penable;
        hit_status = (paddr == pia_pkg::ADDR_STATUS);
        hit_mask = (paddr == pia_pkg::ADDR_MASK);
        hit_config = (paddr == pia_pkg::ADDR_CONFIG);
        unmapped = ~(hit_status | hit_mask | hit_config);
    end
endmodule

`default_nettype wire

// [verilog/pia_irq_drive.sv]
// Purpose: request pin driver, push-pull or open drain
// Assumes: inputs from the core clock domain
// Notes: output and enable come from flip-flops
`timescale 1ns/1ps
`default_nettype none

module pia_irq_drive (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic request,
    input wire logic global_mask,
    input wire logic open_drain_sel,
    // pin
    output logic irq_n_out,
    output logic irq_n_oe
);
    logic assert_pin;
    logic next_irq_n_out;
    logic next_irq_n_oe;

    always_comb begin
        assert_pin = request & ~global_mask; // see R17
        if (open_drain_sel) begin // see R16
            next_irq_n_out = 1'b0;
            next_irq_n_oe = assert_pin;
        end else begin
            next_irq_n_out = ~assert_pin; // see R14
            next_irq_n_oe = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_out <= 1'b1;
            irq_n_oe <= 1'b1;
        end else begin
            irq_n_out <= next_irq_n_out;
            irq_n_oe <= next_irq_n_oe;
        end
    end
endmodule

`default_nettype wire

// [verilog/pia_pkg.sv]
// Purpose: constants for the primary interrupt aggregator
// Assumes: APB slave, 32-bit data, one core clock
// Notes: register byte addresses, field positions, reset values
//
// What this block does
// R01 - status register is read only; writes change no status bit
// R02 - status bit sets when any unmasked secondary flag of its group is set
// R03 - status bit clears only when all its secondaries are cleared or masked
// R04 - a masked primary never asserts the request pin
// R05 - status bits update and read normally whatever the mask bits hold
// R06 - every primary mask bit is one after reset
// R07 - power-state bit 15, thermal bit 14, gpio-pin bit 13, masks alike
// R08 - on-button bit 12, watchdog bit 11, aux converter bit 8, masks alike
// R09 - power-path bit 7, clock-calendar bit 5, one-time memory bit 4
// R10 - high-current bit 1, undervoltage bit 0, masks alike
// R11 - a status bit reads one when asserted, zero when nothing is pending
// R12 - mask bit zero passes its primary to the pin, one blocks it
// R13 - bits 10, 9, 6, 3 and 2 read zero and ignore writes
// R14 - request pin is active low: low while any unmasked primary is set
// R15 - secondaries latch until written one; reading does not clear them
// R16 - open-drain select: zero push-pull, one open drain with pull-up
// R17 - global pin mask keeps the pin high or released whatever is pending

package pia_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 16;
    localparam logic [15:0] ADDR_STATUS = 16'h4010;
    localparam logic [15:0] ADDR_MASK = 16'h4018;
    localparam logic [15:0] ADDR_CONFIG = 16'h401c;
    // implemented primary positions
    localparam int BIT_POWER_STATE = 15;
    localparam int BIT_THERMAL = 14;
    localparam int BIT_GPIO_PIN = 13;
    localparam int BIT_ON_BUTTON = 12;
    localparam int BIT_WATCHDOG = 11;
    localparam int BIT_AUX_CONV = 8;
    localparam int BIT_POWER_PATH = 7;
    localparam int BIT_CLOCK_CAL = 5;
    localparam int BIT_ONETIME_MEM = 4;
    localparam int BIT_HIGH_CURRENT = 1;
    localparam int BIT_UNDERVOLTAGE = 0;
    localparam logic [15:0] VALID_BITS = 16'hf9b3;
    localparam logic [15:0] MASK_RESET = 16'hf9b3;
    // config register fields
    localparam int CFG_GLOBAL_MASK_BIT = 0;
    localparam int CFG_OPEN_DRAIN_BIT = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// [verilog/pia_top.sv]
// Purpose: primary interrupt status, mask and request pin
// Assumes: secondary flags are latched and masked outside
// Notes: APB slave, zero wait states, read data staged in setup
`timescale 1ns/1ps
`default_nettype none

module pia_top #(
    parameter int NUM_BITS = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // unmasked secondary flags, or-ed per primary
    input wire logic [15:0] secondary_any,
    // request pin
    output logic irq_n_out,
    output logic irq_n_oe
);

    ////////////////////////////////////////////////////////////////////
    // elaboration check

    if (NUM_BITS != pia_pkg::REG_W) begin : g_bad_width
        $error("pia_top: NUM_BITS must equal the register width");
    end

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic setup;
    logic access;
    logic hit_status;
    logic hit_mask;
    logic hit_config;
    logic unmapped;
    logic wr_en;

    logic [15:0] status;
    logic [15:0] next_status;
    logic [15:0] mask;
    logic [15:0] next_mask;
    logic [1:0] cfg;
    logic [1:0] next_cfg;
    logic [31:0] next_prdata;
    logic [15:0] pending;
    logic request;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    pia_apb_decode u_decode (
        .psel(psel),
        .penable(penable),
        .paddr(paddr),
        .setup(setup),
        .access(access),
        .hit_status(hit_status),
        .hit_mask(hit_mask),
        .hit_config(hit_config),
        .unmapped(unmapped)
    );

    // no wait states; error only for unmapped addresses
    assign pready = 1'b1;
    assign pslverr = access & unmapped;
    assign wr_en = access & pwrite & ~unmapped;

    ////////////////////////////////////////////////////////////////////
    // primary status

    always_comb begin
        // follows the or of unmasked secondaries, whatever the mask
        next_status = secondary_any & pia_pkg::VALID_BITS; // see R02
        // see R03 see R05 see R13 see R15
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 16'h0000;
        end else begin
            status <= next_status; // see R01 see R11
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mask and pin configuration

    always_comb begin
        next_mask = mask;
        next_cfg = cfg;
        if (wr_en && hit_mask) begin // see R12
            if (pstrb[0]) begin
                next_mask[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                next_mask[15:8] = pwdata[15:8];
            end
        end
        if (wr_en && hit_config && pstrb[0]) begin
            next_cfg = pwdata[1:0];
        end
        next_mask = next_mask & pia_pkg::VALID_BITS; // see R13
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= pia_pkg::MASK_RESET; // see R06
            cfg <= pia_pkg::CFG_RESET;
        end else begin
            mask <= next_mask;
            cfg <= next_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, staged in the setup cycle

    always_comb begin
        next_prdata = prdata;
        if (setup && !pwrite) begin
            next_prdata = pia_pkg::RDATA_ZERO;
            if (hit_status) begin
                next_prdata[15:0] = status; // see R07 see R08
            end else if (hit_mask) begin
                next_prdata[15:0] = mask; // see R09 see R10
            end else if (hit_config) begin
                next_prdata[1:0] = cfg;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= pia_pkg::RDATA_ZERO;
        end else begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-primary gating onto the request

    for (genvar i = 0; i < NUM_BITS; i++) begin : g_gate
        if (pia_pkg::VALID_BITS[i]) begin : g_live
            assign pending[i] = status[i] & ~mask[i]; // see R04
        end else begin : g_resv
            assign pending[i] = 1'b0;
        end
    end

    assign request = |pending;

    pia_irq_drive u_drive (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .request(request),
        .global_mask(cfg[pia_pkg::CFG_GLOBAL_MASK_BIT]),
        .open_drain_sel(cfg[pia_pkg::CFG_OPEN_DRAIN_BIT]),
        .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe)
    );

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic first_cycle;
    logic pin_low;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    // pin is pulled low when enabled and driving zero
    assign pin_low = irq_n_oe & ~irq_n_out;

    AST_STATUS_RO: // see R01
    assert property (wr_en && hit_status |=>
        status == ($past(secondary_any) & pia_pkg::VALID_BITS))
    else $error("write to status altered a status bit");

    AST_STATUS_SET: // see R02
    assert property ((secondary_any & pia_pkg::VALID_BITS) != 16'h0000
        |=> status != 16'h0000)
    else $error("status not set by unmasked secondary");

    AST_STATUS_CLEAR: // see R03
    assert property ((secondary_any & pia_pkg::VALID_BITS) == 16'h0000
        |=> status == 16'h0000)
    else $error("status not cleared after secondaries cleared");

    AST_MASKED_QUIET: // see R04
    assert property ((status & ~mask) == 16'h0000 |=> !pin_low)
    else $error("masked primary asserted the pin");

    AST_STATUS_IGNORES_MASK: // see R05
    assert property (secondary_any[pia_pkg::BIT_WATCHDOG]
        && mask[pia_pkg::BIT_WATCHDOG]
        |=> status[pia_pkg::BIT_WATCHDOG])
    else $error("masked primary not shown in status");

    AST_MASK_RESET: // see R06
    assert property (first_cycle |-> mask == pia_pkg::MASK_RESET)
    else $error("mask not all ones after reset");

    AST_MASK_HOLD: // see R06
    assert property (!(wr_en && hit_mask) |=> $stable(mask))
    else $error("mask changed without a write");

    AST_MAP_HIGH: // see R07
    assert property (status[15:13] == $past(secondary_any[15:13]))
    else $error("power, thermal or gpio-pin bit misplaced");

    AST_MAP_MID: // see R08
    assert property ({status[12:11], status[8]} ==
        {$past(secondary_any[12:11]), $past(secondary_any[8])})
    else $error("on-button, watchdog or aux bit misplaced");

    AST_MAP_LOW: // see R09
    assert property ({status[7], status[5:4]} ==
        {$past(secondary_any[7]), $past(secondary_any[5:4])})
    else $error("power-path, clock or memory bit misplaced");

    AST_MAP_BOTTOM: // see R10
    assert property (status[1:0] == $past(secondary_any[1:0]))
    else $error("high-current or undervoltage bit misplaced");

    AST_READ_STATUS: // see R11
    assert property (setup && !pwrite && hit_status
        |=> prdata == {16'h0000, $past(status)})
    else $error("status read returned wrong value");

    AST_MASK_WRITE: // see R12
    assert property (wr_en && hit_mask && pstrb[1:0] == 2'h3
        |=> mask == ($past(pwdata[15:0]) & pia_pkg::VALID_BITS))
    else $error("mask write not stored");

    AST_RESERVED_ZERO: // see R13
    assert property (((status | mask) & ~pia_pkg::VALID_BITS) == 16'h0000)
    else $error("reserved bit is nonzero");

    AST_PIN_ACTIVE: // see R14
    assert property (request && !cfg[pia_pkg::CFG_GLOBAL_MASK_BIT]
        && !cfg[pia_pkg::CFG_OPEN_DRAIN_BIT]
        ##1 !cfg[pia_pkg::CFG_OPEN_DRAIN_BIT] |-> !irq_n_out && irq_n_oe)
    else $error("pin not low for unmasked primary");

    AST_OPEN_DRAIN: // see R16
    assert property (cfg[pia_pkg::CFG_OPEN_DRAIN_BIT]
        && $stable(cfg) |-> !irq_n_out)
    else $error("open drain drove the pin high");

    AST_PUSH_PULL: // see R16
    assert property (!cfg[pia_pkg::CFG_OPEN_DRAIN_BIT]
        && $stable(cfg) |-> irq_n_oe)
    else $error("push-pull pin released");

    AST_GLOBAL_MASK: // see R17
    assert property (cfg[pia_pkg::CFG_GLOBAL_MASK_BIT] |=> !pin_low)
    else $error("globally masked pin asserted");

    AST_UNMAPPED_ERR:
    assert property (access && unmapped |-> pslverr && pready)
    else $error("unmapped access without error");

    AST_PIN_IDLE: // see R14
    assert property (!request && !cfg[pia_pkg::CFG_OPEN_DRAIN_BIT]
        |=> irq_n_out && irq_n_oe)
    else $error("push-pull pin low with nothing pending");

    AST_OD_DRIVE: // see R16
    assert property (request && cfg[pia_pkg::CFG_OPEN_DRAIN_BIT]
        && !cfg[pia_pkg::CFG_GLOBAL_MASK_BIT] |=> irq_n_oe && !irq_n_out)
    else $error("open drain pin not pulled low");

    AST_OD_RELEASE: // see R16
    assert property (!request && cfg[pia_pkg::CFG_OPEN_DRAIN_BIT] |=> !irq_n_oe)
    else $error("open drain pin not released");

    AST_GLOBAL_PP_HIGH: // see R17
    assert property (cfg[pia_pkg::CFG_GLOBAL_MASK_BIT]
        && !cfg[pia_pkg::CFG_OPEN_DRAIN_BIT] |=> irq_n_out && irq_n_oe)
    else $error("globally masked push-pull pin not high");

    AST_CFG_HOLD: // see R16
    assert property (!(wr_en && hit_config) |=> $stable(cfg))
    else $error("pin config changed without a write");

    AST_READ_MASK: // see R12
    assert property (setup && !pwrite && hit_mask
        |=> prdata == {16'h0000, $past(mask)})
    else $error("mask read returned wrong value");

    AST_READ_CONFIG: // see R16
    assert property (setup && !pwrite && hit_config
        |=> prdata == {30'h0, $past(cfg)})
    else $error("config read returned wrong value");

    AST_READ_UNMAPPED:
    assert property (setup && !pwrite && unmapped
        |=> prdata == pia_pkg::RDATA_ZERO)
    else $error("unmapped read returned nonzero data");

    AST_READ_RESERVED: // see R13
    assert property (prdata[31:16] == 16'h0000
        && (prdata[15:0] & ~pia_pkg::VALID_BITS) == 16'h0000)
    else $error("reserved read bit is nonzero");

    AST_MASK_LANE: // see R12
    assert property (wr_en && hit_mask && pstrb[1:0] == 2'h1
        |=> mask[15:8] == $past(mask[15:8])
        && mask[7:0] == ($past(pwdata[7:0]) & pia_pkg::VALID_BITS[7:0]))
    else $error("byte lane write to mask misapplied");

    AST_MAPPED_OKAY:
    assert property (access && !unmapped |-> !pslverr)
    else $error("error response on a mapped register");

    COV_PIN_ASSERT:
    cover property (request ##1 pin_low);

    COV_MASK_WRITE:
    cover property (wr_en && hit_mask ##1 mask != pia_pkg::MASK_RESET);

    COV_OPEN_DRAIN:
    cover property (cfg[pia_pkg::CFG_OPEN_DRAIN_BIT] && irq_n_oe);

    COV_UNMAPPED:
    cover property (pslverr);

    COV_GLOBAL_MASK:
    cover property (cfg[pia_pkg::CFG_GLOBAL_MASK_BIT] && request);

endmodule

`default_nettype wire
